// ==== design/asw_status_top.sv ====
// Acquisition status word with its flags, run control and sample FIFO
`timescale 1ns/100ps
`default_nettype none
module asw_status_top #(
    parameter int FIFO_DEPTH = asw_pkg::FIFO_DEPTH,
    parameter int FIFO_AW = asw_pkg::FIFO_AW,
    parameter int HALF_LEVEL = asw_pkg::HALF_LEVEL
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [asw_pkg::ADDR_W-1:0] IO_ADDR,
    input wire logic IO_RD,
    input wire logic IO_WR,
    output logic [asw_pkg::DATA_W-1:0] IO_RDATA,
    input wire logic CONV_START,
    input wire logic CONV_BUSY,
    input wire logic CONV_RESULT_VALID,
    input wire logic [asw_pkg::DATA_W-1:0] CONV_DATA,
    input wire logic SAMPLE_COUNT_TC,
    input wire logic EXT_TRIG_N,
    input wire logic DMA_TC_A,
    input wire logic DMA_TC_B,
    input wire logic TRANSFER_DONE_IRQ_ENABLE,
    input wire logic DRAIN_REQUEST_ENABLE,
    input wire logic CONV_IRQ_ENABLE,
    input wire logic HALF_FULL_MODE,
    input wire logic OUTPUT_UPDATE_TRIGGER_N,
    input wire logic DAC_VALUE_WRITTEN,
    input wire logic WAVEFORM_MODE,
    input wire logic SCAN_LIST_LOADED,
    input wire logic FACTORY_CAL_N,
    input wire logic EEPROM_DATA_OUT,
    input wire logic EEPROM_DESELECT_N,
    output logic ACQ_ENABLE,
    output logic CONV_IRQ,
    output logic DRAIN_REQ,
    output logic TC_IRQ,
    output logic SCAN_LIST_RESTART
);
    // Strobe decode shared by every write-only location
    function automatic logic hit(input logic [asw_pkg::ADDR_W-1:0] addr,
                                 input logic [asw_pkg::ADDR_W-1:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    logic acq_clr;
    logic start_wr;
    logic tc_clr;
    logic upd_clr;
    logic fifo_rd;

    always_comb begin
        acq_clr = 1'b0;
        start_wr = 1'b0;
        tc_clr = 1'b0;
        upd_clr = 1'b0;
        if (IO_WR) begin
            if (hit(IO_ADDR, asw_pkg::OFS_ACQ_CLEAR)) begin
                acq_clr = 1'b1;
            end else if (hit(IO_ADDR, asw_pkg::OFS_START_DAQ)) begin
                start_wr = 1'b1;
            end else if (hit(IO_ADDR, asw_pkg::OFS_TC_CLEAR)) begin
                tc_clr = 1'b1;
            end else if (hit(IO_ADDR, asw_pkg::OFS_UPDATE_CLEAR)) begin
                upd_clr = 1'b1;
            end
        end
    end

    // Only the FIFO data location pops; the status word read is passive
    assign fifo_rd = IO_RD && hit(IO_ADDR, asw_pkg::OFS_FIFO_DATA);

    // Sample FIFO
    logic [asw_pkg::DATA_W-1:0] fifo_dout;
    logic [FIFO_AW:0] fifo_count;
    logic fifo_full;
    logic fifo_empty;

    asw_sample_fifo #(
        .WIDTH(asw_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(REF_CLK),
        .rst(RST),
        .push(CONV_RESULT_VALID),
        .din(CONV_DATA),
        .pop(fifo_rd),
        .flush(acq_clr),
        .dout(fifo_dout),
        .count(fifo_count),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // Error events
    logic lost_evt;
    logic skip_evt;
    assign lost_evt = CONV_RESULT_VALID && fifo_full;
    assign skip_evt = CONV_START && CONV_BUSY;

    // Run control
    asw_pkg::asw_run_t run_r;
    logic ext_trig_n_d_r;
    logic start_evt;
    logic run_end;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ext_trig_n_d_r <= 1'b1;
        end else begin
            ext_trig_n_d_r <= EXT_TRIG_N;
        end
    end

    // A held-low external trigger blocks the software start
    assign start_evt = (start_wr && EXT_TRIG_N) || (ext_trig_n_d_r && !EXT_TRIG_N);
    assign run_end = (run_r == asw_pkg::ASW_RUN) && (SAMPLE_COUNT_TC || lost_evt || skip_evt);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            run_r <= asw_pkg::ASW_IDLE;
        end else begin
            case (run_r)
                asw_pkg::ASW_IDLE: begin
                    if (start_evt && !acq_clr) begin
                        run_r <= asw_pkg::ASW_RUN;
                    end
                end
                asw_pkg::ASW_RUN: begin
                    if (acq_clr || run_end) begin
                        run_r <= asw_pkg::ASW_IDLE;
                    end
                end
                default: begin
                    run_r <= asw_pkg::ASW_IDLE;
                end
            endcase
        end
    end

    assign ACQ_ENABLE = (run_r == asw_pkg::ASW_RUN);

    // Output update trigger edge and freshness of the converter value
    logic trig_n_d_r;
    logic upd_fall;
    logic fresh_r;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            trig_n_d_r <= 1'b1;
        end else begin
            trig_n_d_r <= OUTPUT_UPDATE_TRIGGER_N;
        end
    end

    assign upd_fall = trig_n_d_r && !OUTPUT_UPDATE_TRIGGER_N;

    // A write landing with the update counts for the next update
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            fresh_r <= 1'b0;
        end else if (DAC_VALUE_WRITTEN) begin
            fresh_r <= 1'b1;
        end else if (upd_fall) begin
            fresh_r <= 1'b0;
        end
    end

    // Sticky flags
    logic [asw_pkg::FLG_COUNT-1:0] flg_set;
    logic [asw_pkg::FLG_COUNT-1:0] flg_clr;
    logic [asw_pkg::FLG_COUNT-1:0] flg;

    always_comb begin
        flg_set = '0;
        flg_clr = '0;
        flg_set[asw_pkg::FLG_DONE] = run_end;
        flg_set[asw_pkg::FLG_TC_A] = DMA_TC_A;
        flg_set[asw_pkg::FLG_TC_B] = DMA_TC_B;
        flg_set[asw_pkg::FLG_LOST] = lost_evt;
        flg_set[asw_pkg::FLG_SKIP] = skip_evt;
        flg_set[asw_pkg::FLG_UPDATE] = upd_fall;
        flg_set[asw_pkg::FLG_DBL] = upd_fall && WAVEFORM_MODE && !fresh_r;
        flg_clr[asw_pkg::FLG_DONE] = acq_clr;
        flg_clr[asw_pkg::FLG_LOST] = acq_clr;
        flg_clr[asw_pkg::FLG_SKIP] = acq_clr;
        flg_clr[asw_pkg::FLG_TC_A] = tc_clr;
        flg_clr[asw_pkg::FLG_TC_B] = tc_clr;
        flg_clr[asw_pkg::FLG_UPDATE] = upd_clr;
        flg_clr[asw_pkg::FLG_DBL] = upd_clr;
    end

    asw_sticky_bank #(
        .WIDTH(asw_pkg::FLG_COUNT)
    ) u_flags (
        .clk(REF_CLK),
        .rst(RST),
        .set(flg_set),
        .clr(flg_clr),
        .flag(flg)
    );

    // Terminal-count interrupt on a rising flag
    logic tc_a_d_r;
    logic tc_b_d_r;
    logic tc_irq_r;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tc_a_d_r <= 1'b0;
            tc_b_d_r <= 1'b0;
            tc_irq_r <= 1'b0;
        end else begin
            tc_a_d_r <= flg[asw_pkg::FLG_TC_A];
            tc_b_d_r <= flg[asw_pkg::FLG_TC_B];
            tc_irq_r <= TRANSFER_DONE_IRQ_ENABLE &&
                ((flg[asw_pkg::FLG_TC_A] && !tc_a_d_r) || (flg[asw_pkg::FLG_TC_B] && !tc_b_d_r));
        end
    end

    assign TC_IRQ = tc_irq_r;

    // Conversion requests are levels that only draining removes
    logic half_full;
    assign half_full = (fifo_count >= (FIFO_AW+1)'(HALF_LEVEL));
    assign CONV_IRQ = CONV_IRQ_ENABLE && !fifo_empty &&
        (HALF_FULL_MODE ? half_full : 1'b1);
    assign DRAIN_REQ = flg[asw_pkg::FLG_DONE] && DRAIN_REQUEST_ENABLE && !fifo_empty;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            SCAN_LIST_RESTART <= 1'b0;
        end else begin
            SCAN_LIST_RESTART <= acq_clr;
        end
    end

    // Status word assembly
    logic [asw_pkg::DATA_W-1:0] status_w;

    always_comb begin
        status_w = '0;
        status_w[asw_pkg::BIT_DONE] = flg[asw_pkg::FLG_DONE];
        status_w[asw_pkg::BIT_RUNNING] = (run_r == asw_pkg::ASW_RUN);
        status_w[asw_pkg::BIT_HALF_N] = !half_full;
        status_w[asw_pkg::BIT_NONEMPTY] = !fifo_empty;
        status_w[asw_pkg::BIT_TC_ANY] = flg[asw_pkg::FLG_TC_A] | flg[asw_pkg::FLG_TC_B];
        status_w[asw_pkg::BIT_TC_A] = flg[asw_pkg::FLG_TC_A];
        status_w[asw_pkg::BIT_TC_B] = flg[asw_pkg::FLG_TC_B];
        // Error flags read active low, so done with either low is an error end
        status_w[asw_pkg::BIT_LOST_N] = !flg[asw_pkg::FLG_LOST];
        status_w[asw_pkg::BIT_SKIP_N] = !flg[asw_pkg::FLG_SKIP];
        status_w[asw_pkg::BIT_UPDATE] = flg[asw_pkg::FLG_UPDATE];
        status_w[asw_pkg::BIT_DBL_ERR] = flg[asw_pkg::FLG_DBL];
        status_w[asw_pkg::BIT_FACT_CAL_N] = FACTORY_CAL_N;
        status_w[asw_pkg::BIT_PROM_OUT] = EEPROM_DATA_OUT;
        status_w[asw_pkg::BIT_PROM_DESEL_N] = EEPROM_DESELECT_N;
        status_w[asw_pkg::BIT_SCAN_EMPTY_N] = SCAN_LIST_LOADED;
    end

    // Read data is captured on the read cycle and held until the next read
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            IO_RDATA <= asw_pkg::RDATA_RESET;
        end else if (IO_RD) begin
            if (hit(IO_ADDR, asw_pkg::OFS_STATUS)) begin
                IO_RDATA <= status_w;
            end else if (hit(IO_ADDR, asw_pkg::OFS_FIFO_DATA)) begin
                IO_RDATA <= fifo_dout;
            end else begin
                IO_RDATA <= asw_pkg::RDATA_RESET;
            end
        end
    end

    // Checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    AST_STATUS_READ: assert property (
        IO_RD && hit(IO_ADDR, asw_pkg::OFS_STATUS) |=> IO_RDATA == $past(status_w))
        else $error("status read returned wrong word");

    AST_DONE_HOLDS: assert property (
        flg[asw_pkg::FLG_DONE] && !acq_clr |=> flg[asw_pkg::FLG_DONE])
        else $error("done flag dropped without clear");

    // One pop cannot empty a FIFO holding two or more, so the request must stand
    AST_DRAIN_REQ: assert property (
        DRAIN_REQ && !acq_clr && fifo_count > 1 |=> DRAIN_REQ || !DRAIN_REQUEST_ENABLE)
        else $error("drain request dropped before empty");

    AST_RUN_STOPS_ON_END: assert property (
        ACQ_ENABLE && SAMPLE_COUNT_TC && !acq_clr |=> !ACQ_ENABLE && flg[asw_pkg::FLG_DONE])
        else $error("run did not complete");

    AST_HALF_FLAG: assert property (
        status_w[asw_pkg::BIT_HALF_N] == (fifo_count < (FIFO_AW+1)'(HALF_LEVEL)))
        else $error("half flag disagrees with count");

    AST_NO_IRQ_EMPTY: assert property (
        fifo_empty |-> !CONV_IRQ && !status_w[asw_pkg::BIT_NONEMPTY])
        else $error("conversion request while empty");

    AST_TC_OR: assert property (
        status_w[asw_pkg::BIT_TC_ANY] == (status_w[asw_pkg::BIT_TC_A] || status_w[asw_pkg::BIT_TC_B]))
        else $error("terminal count OR wrong");

    AST_TC_A_STICKY: assert property (
        DMA_TC_A || (flg[asw_pkg::FLG_TC_A] && !tc_clr) |=> flg[asw_pkg::FLG_TC_A])
        else $error("channel A flag not sticky");

    AST_TC_IRQ: assert property (
        TRANSFER_DONE_IRQ_ENABLE && $rose(flg[asw_pkg::FLG_TC_A]) |=> TC_IRQ)
        else $error("terminal count interrupt missing");

    AST_LOST_ENDS_RUN: assert property (
        ACQ_ENABLE && lost_evt |=> !ACQ_ENABLE && !status_w[asw_pkg::BIT_LOST_N])
        else $error("overflow did not end run");

    AST_SKIP_ENDS_RUN: assert property (
        ACQ_ENABLE && skip_evt |=> !ACQ_ENABLE && !status_w[asw_pkg::BIT_SKIP_N])
        else $error("overrun did not end run");

    AST_CLEAR_ALL: assert property (
        acq_clr && !CONV_RESULT_VALID && !CONV_START && !SAMPLE_COUNT_TC |=>
        fifo_empty && !ACQ_ENABLE && !flg[asw_pkg::FLG_DONE] && status_w[asw_pkg::BIT_LOST_N]
        && status_w[asw_pkg::BIT_SKIP_N] && SCAN_LIST_RESTART)
        else $error("clear strobe left state behind");

    AST_UPDATE_SET: assert property (
        upd_fall |=> flg[asw_pkg::FLG_UPDATE])
        else $error("update flag not set");

    COV_NORMAL_END: cover property (ACQ_ENABLE && SAMPLE_COUNT_TC && !lost_evt && !skip_evt);
    COV_OVERFLOW: cover property (ACQ_ENABLE && lost_evt);
    COV_TC_IRQ: cover property (TC_IRQ);
    COV_DBL_ERR: cover property ($rose(flg[asw_pkg::FLG_DBL]));
endmodule : asw_status_top
`default_nettype wire

// ==== shared/asw_pkg.sv ====
// Constants, offsets and types shared by the acquisition status word block
// How it works
// - Read-only 16-bit status word at offset zero
// - Bit 15 done holds until clear strobe
// - Done with error flag low means error
// - After done, drain requests until FIFO empty
// - Bit 14 set while acquisition runs
// - Bit 13 low when 128 or more held
// - Half-full interrupt clears only by draining FIFO
// - Bit 12 nonempty; empty blocks conversion interrupt
// - Nonempty interrupt persists until FIFO emptied
// - Bit 11 is OR of both done flags
// - Bit 10 channel A done, sticky until clear
// - Bit 9 channel B done, sticky until clear
// - Interrupt on rising done flag when enabled
// - Bit 8 low after push into full FIFO
// - FIFO overflow ends the run at once
// - Bit 7 low when conversion started while busy
// - Conversion overrun ends the run at once
// - Clear strobe returns both error flags high
// - Clear strobe cancels run, flushes, restarts list
// - Bit 6 set on trigger fall, cleared by strobe
// - Bit 5 set on update without new value, in waveform mode only
// - Bit 0 low when scan memory empty
package asw_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 256;
    localparam int FIFO_AW = 8;
    localparam int HALF_LEVEL = 128;

    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_FIFO_DATA = 5'h02;
    localparam logic [ADDR_W-1:0] OFS_START_DAQ = 5'h0a;
    localparam logic [ADDR_W-1:0] OFS_ACQ_CLEAR = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_TC_CLEAR = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_UPDATE_CLEAR = 5'h12;

    localparam int BIT_DONE = 15;
    localparam int BIT_RUNNING = 14;
    localparam int BIT_HALF_N = 13;
    localparam int BIT_NONEMPTY = 12;
    localparam int BIT_TC_ANY = 11;
    localparam int BIT_TC_A = 10;
    localparam int BIT_TC_B = 9;
    localparam int BIT_LOST_N = 8;
    localparam int BIT_SKIP_N = 7;
    localparam int BIT_UPDATE = 6;
    localparam int BIT_DBL_ERR = 5;
    localparam int BIT_FACT_CAL_N = 4;
    localparam int BIT_PROM_OUT = 3;
    localparam int BIT_PROM_DESEL_N = 2;
    localparam int BIT_SCAN_EMPTY_N = 0;

    // Sticky flag slots in the flag bank
    localparam int FLG_DONE = 0;
    localparam int FLG_TC_A = 1;
    localparam int FLG_TC_B = 2;
    localparam int FLG_LOST = 3;
    localparam int FLG_SKIP = 4;
    localparam int FLG_UPDATE = 5;
    localparam int FLG_DBL = 6;
    localparam int FLG_COUNT = 7;

    localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

    typedef enum logic {ASW_IDLE, ASW_RUN} asw_run_t;
endpackage : asw_pkg

// ==== design/asw_sticky_bank.sv ====
// Bank of sticky flags where a hardware set beats a software clear
`timescale 1ns/100ps
`default_nettype none
module asw_sticky_bank #(
    parameter int WIDTH = 7
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flag
);
    logic [WIDTH-1:0] flag_r;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_flag
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag_r[g] <= 1'b0;
                end else if (set[g]) begin
                    flag_r[g] <= 1'b1;
                end else if (clr[g]) begin
                    flag_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flag = flag_r;
endmodule : asw_sticky_bank
`default_nettype wire

// ==== design/asw_sample_fifo.sv ====
// Sample FIFO holding conversion results with occupancy count
`timescale 1ns/100ps
`default_nettype none
module asw_sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] din,
    input wire logic pop,
    input wire logic flush,
    output logic [WIDTH-1:0] dout,
    output logic [AW:0] count,
    output logic full,
    output logic empty
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic do_push;
    logic do_pop;

    assign full = (count_r == (AW+1)'(DEPTH));
    assign empty = (count_r == '0);
    // A push into a full FIFO is dropped; the caller flags the loss
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= din;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_r <= count_r + 1'b1;
            end else if (do_pop && !do_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    assign dout = empty ? '0 : mem[rd_ptr_r];
    assign count = count_r;
endmodule : asw_sample_fifo
`default_nettype wire

// ==== tb/asw_testbench.sv ====
// Self-checking testbench for the acquisition status word block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk, rst, io_rd, io_wr, conv_busy, conv_valid, ext_trig_n;
    logic tc_en, drain_en, conv_en, half_mode, upd_trig_n, wave_mode;
    logic scan_loaded, fact_cal_n, prom_out, prom_desel_n;
    logic acq_enable, conv_irq, drain_req, tc_irq, scan_restart;
    logic [4:0] io_addr;
    logic [4:0] pls;
    logic [15:0] io_rdata, conv_data, d;
    int errors = 0;
    int cmp_count = 0;
    int tc_cnt = 0;
    int rs_cnt = 0;

    // Pulse inputs share one vector so a single task can strobe any of them
    asw_status_top #(.FIFO_DEPTH(8), .FIFO_AW(3), .HALF_LEVEL(4)) i_asw_status_top (
        .REF_CLK(ref_clk), .RST(rst), .IO_ADDR(io_addr), .IO_RD(io_rd), .IO_WR(io_wr),
        .IO_RDATA(io_rdata), .CONV_START(pls[4]), .CONV_BUSY(conv_busy),
        .CONV_RESULT_VALID(conv_valid), .CONV_DATA(conv_data), .SAMPLE_COUNT_TC(pls[0]),
        .EXT_TRIG_N(ext_trig_n), .DMA_TC_A(pls[1]), .DMA_TC_B(pls[2]),
        .TRANSFER_DONE_IRQ_ENABLE(tc_en), .DRAIN_REQUEST_ENABLE(drain_en),
        .CONV_IRQ_ENABLE(conv_en), .HALF_FULL_MODE(half_mode), .OUTPUT_UPDATE_TRIGGER_N(upd_trig_n),
        .DAC_VALUE_WRITTEN(pls[3]), .WAVEFORM_MODE(wave_mode), .SCAN_LIST_LOADED(scan_loaded),
        .FACTORY_CAL_N(fact_cal_n), .EEPROM_DATA_OUT(prom_out), .EEPROM_DESELECT_N(prom_desel_n),
        .ACQ_ENABLE(acq_enable), .CONV_IRQ(conv_irq), .DRAIN_REQ(drain_req), .TC_IRQ(tc_irq),
        .SCAN_LIST_RESTART(scan_restart)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // One-cycle outputs are counted here so a check cannot miss the cycle they stand in
    always @(posedge ref_clk) begin
        if (tc_irq === 1'b1) tc_cnt++;
        if (scan_restart === 1'b1) rs_cnt++;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chkb

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge ref_clk);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask : rd

    task automatic st(input logic [15:0] m, input logic [15:0] e, input string w);
        rd(5'h00);
        chk(d & m, e, w);
    endtask : st

    task automatic wr(input logic [4:0] a);
        @(posedge ref_clk);
        io_wr <= 1'b1;
        io_addr <= a;
        @(posedge ref_clk);
        io_wr <= 1'b0;
    endtask : wr

    task automatic pulse(input int i);
        @(posedge ref_clk);
        pls <= 5'h01 << i;
        @(posedge ref_clk);
        pls <= 5'h00;
    endtask : pulse

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            conv_valid <= 1'b1;
            conv_data <= 16'ha001 + 16'(i);
        end
        @(posedge ref_clk);
        conv_valid <= 1'b0;
    endtask : push

    task automatic t_reset;
        chkb(acq_enable, 1'b0, "idle after reset");
        chkb(conv_irq | drain_req | tc_irq | scan_restart, 1'b0, "outputs after reset");
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            {fact_cal_n, prom_out, prom_desel_n, scan_loaded} <= {4{i[0]}};
            st(16'hffff, i[0] ? 16'h219d : 16'h2180, "status at reset");
            st(16'hffff, i[0] ? 16'h219d : 16'h2180, "status reread");
        end
        rd(5'h1e);
        chk(d, 16'h0000, "unmapped read");
        $display("test reset done");
    endtask : t_reset

    task automatic t_run;
        int r;
        @(posedge ref_clk);
        conv_en <= 1'b1;
        half_mode <= 1'b1;
        drain_en <= 1'b1;
        wr(5'h0a);
        cyc(1);
        chkb(acq_enable, 1'b1, "run started");
        push(4);
        st(16'hf000, 16'h5000, "four words held");
        chkb(conv_irq, 1'b1, "half level request");
        rd(5'h02);
        chk(d, 16'ha001, "first word");
        st(16'h3000, 16'h3000, "below half level");
        chkb(conv_irq, 1'b0, "half request drained");
        @(posedge ref_clk);
        half_mode <= 1'b0;
        pulse(0);
        cyc(2);
        chkb(acq_enable, 1'b0, "run ended");
        st(16'hc180, 16'h8180, "clean completion");
        chkb(drain_req & conv_irq, 1'b1, "drain requests");
        for (int i = 1; i < 4; i++) begin
            chkb(conv_irq, 1'b1, "nonempty request held");
            rd(5'h02);
            chk(d, 16'ha001 + 16'(i), "fifo word");
        end
        chkb(conv_irq | drain_req, 1'b0, "requests drop when empty");
        rd(5'h02);
        chk(d, 16'h0000, "pop from empty");
        st(16'h9000, 16'h8000, "done holds over reads");
        r = rs_cnt;
        wr(5'h0c);
        cyc(3);
        chk(16'(rs_cnt - r), 16'h0001, "scan restart pulse");
        st(16'h8000, 16'h0000, "done cleared");
        $display("test run done");
    endtask : t_run

    task automatic t_overflow;
        wr(5'h0a);
        push(9);
        cyc(2);
        chkb(acq_enable, 1'b0, "overflow ends run");
        st(16'hc180, 16'h8080, "overflow flagged");
        wr(5'h0c);
        cyc(1);
        st(16'h9180, 16'h0180, "overflow cleared");
        rd(5'h02);
        chk(d, 16'h0000, "fifo flushed");
        $display("test overflow done");
    endtask : t_overflow

    task automatic t_overrun;
        @(posedge ref_clk);
        ext_trig_n <= 1'b0;
        cyc(2);
        chkb(acq_enable, 1'b1, "trigger start");
        @(posedge ref_clk);
        ext_trig_n <= 1'b1;
        conv_busy <= 1'b1;
        pulse(4);
        @(posedge ref_clk);
        conv_busy <= 1'b0;
        cyc(1);
        chkb(acq_enable, 1'b0, "overrun ends run");
        st(16'hc180, 16'h8100, "overrun flagged");
        wr(5'h0c);
        cyc(1);
        st(16'h8180, 16'h0180, "overrun cleared");
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_dma;
        int b;
        @(posedge ref_clk);
        tc_en <= 1'b1;
        b = tc_cnt;
        pulse(1);
        cyc(3);
        chk(16'(tc_cnt - b), 16'h0001, "request on A");
        st(16'h0e00, 16'h0c00, "A flagged");
        pulse(1);
        pulse(2);
        cyc(3);
        chk(16'(tc_cnt - b), 16'h0002, "only B rises again");
        st(16'h0e00, 16'h0e00, "both flagged");
        wr(5'h10);
        cyc(1);
        st(16'h0e00, 16'h0000, "terminal counts cleared");
        @(posedge ref_clk);
        tc_en <= 1'b0;
        b = tc_cnt;
        pulse(2);
        cyc(3);
        chk(16'(tc_cnt - b), 16'h0000, "request disabled");
        st(16'h0e00, 16'h0a00, "B alone");
        wr(5'h10);
        $display("test dma done");
    endtask : t_dma

    task automatic t_update;
        @(posedge ref_clk);
        wave_mode <= 1'b1;
        upd_trig_n <= 1'b0;
        cyc(2);
        @(posedge ref_clk);
        upd_trig_n <= 1'b1;
        st(16'h0060, 16'h0060, "update without new value");
        wr(5'h12);
        cyc(1);
        st(16'h0060, 16'h0000, "update flags cleared");
        pulse(3);
        @(posedge ref_clk);
        upd_trig_n <= 1'b0;
        cyc(2);
        @(posedge ref_clk);
        upd_trig_n <= 1'b1;
        st(16'h0060, 16'h0040, "update with new value");
        wr(5'h12);
        $display("test update done");
    endtask : t_update

    initial begin
        rst = 1'b1;
        {io_rd, io_wr, conv_busy, conv_valid, tc_en, drain_en, conv_en, half_mode} = 8'h00;
        {wave_mode, scan_loaded, fact_cal_n, prom_out, prom_desel_n} = 5'h00;
        ext_trig_n = 1'b1;
        upd_trig_n = 1'b1;
        io_addr = 5'h00;
        pls = 5'h00;
        conv_data = 16'h0000;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        t_reset;
        t_run;
        t_overflow;
        t_overrun;
        t_dma;
        t_update;
        end_of_test;
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
